// ### dv/ppch_periph.sv
`timescale 1ns/1ps
`default_nettype none
module ppch_periph (
  input wire logic hclk,
  input wire logic [7:0] data_pins_out,
  input wire logic write_strobe_pin_out,
  input wire logic write_strobe_pin_oe_n,
  input wire logic byte_enable_pin_out,
  input wire logic byte_enable_pin_oe_n,
  output logic [7:0] data_pins_in,
  output logic [1:0] address_pins_in,
  output logic read_strobe_pin_in,
  output logic write_strobe_pin_in,
  output logic chip_select_pin_in
);
  logic wr_act;
  logic wr_prev = 1'b0;
  logic host_cs = 1'b0;
  logic host_wr = 1'b0;
  logic [8:0] seen[$];
  // Latch device on the write strobe, and a host for slave tests; strobes idle low (active high)
  assign wr_act = write_strobe_pin_out && !write_strobe_pin_oe_n;
  assign address_pins_in = 2'h2;
  assign read_strobe_pin_in = 1'b0;
  assign write_strobe_pin_in = host_wr;
  assign chip_select_pin_in = host_cs;
  initial data_pins_in = 8'h00;
  // Undriven bus toggles so a stale byte never looks valid
  always @(posedge hclk) begin
    data_pins_in <= ~data_pins_in;
    wr_prev <= wr_act;
    if (wr_act && !wr_prev) seen.push_back({byte_enable_pin_out && !byte_enable_pin_oe_n, data_pins_out});
  end
  // Host write: phases of four cycles, above the port's three-cycle minimum
  task automatic host_write();
    host_cs <= 1'b1;
    repeat (4) @(posedge hclk);
    host_wr <= 1'b1;
    repeat (4) @(posedge hclk);
    host_wr <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : host_write
endmodule : ppch_periph
`default_nettype wire

// ### dv/ppch_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppch_port_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic data_pins_oe_n,
  input wire logic [7:0] address_pins_oe_n,
  input wire logic read_strobe_pin_own,
  input wire logic write_strobe_pin_own,
  input wire logic byte_enable_pin_own
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic ctl_ph_reg;
  logic [7:0] ctl_reg;
  // Shadow of the control-high byte, updated at the same edge as the design
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_ph_reg <= 1'b0;
      ctl_reg <= 8'h00;
    end else if (hready) begin
      ctl_ph_reg <= take && hwrite && haddr[13:2] == ppch_pkg::IDX_CTL_HI;
      if (ctl_ph_reg) ctl_reg <= hwdata[7:0];
    end
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_low_once: assert property ($fell(hreadyout) |=> hreadyout)
    else $error("wait state too long");
  a_rdata_top: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_off_quiet: assert property (!ctl_reg[7] && !$past(ctl_reg[7]) |-> data_pins_oe_n && &address_pins_oe_n)
    else $error("pins driven while off");
  a_rd_own: assert property (read_strobe_pin_own == $past(ctl_reg[7] && ctl_reg[0]))
    else $error("read strobe ownership wrong");
  a_wr_own: assert property (write_strobe_pin_own == $past(ctl_reg[7] && ctl_reg[1]))
    else $error("write strobe ownership wrong");
  a_be_own: assert property (byte_enable_pin_own == $past(ctl_reg[7] && ctl_reg[2]))
    else $error("byte enable ownership wrong");
endmodule : ppch_port_props
bind ppch_port ppch_port_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .data_pins_oe_n(data_pins_oe_n),
  .address_pins_oe_n(address_pins_oe_n), .read_strobe_pin_own(read_strobe_pin_own),
  .write_strobe_pin_own(write_strobe_pin_own), .byte_enable_pin_own(byte_enable_pin_own));
`default_nettype wire

// ### dv/ppch_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ppch_port_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, wr_out, wr_oe_n, be_out, be_oe_n, rd_own, wr_own, be_own, rd_in, wr_in, cs_in;
  logic [1:0] a_in;
  logic [7:0] d_in, d_out;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
  always #25 hclk = ~hclk;
  ppch_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .data_pins_in(d_in), .data_pins_out(d_out), .data_pins_oe_n(),
    .address_pins_in(a_in), .address_pins_out(), .address_pins_oe_n(), .read_strobe_pin_in(rd_in),
    .read_strobe_pin_out(), .read_strobe_pin_oe_n(), .read_strobe_pin_own(rd_own),
    .write_strobe_pin_in(wr_in), .write_strobe_pin_out(wr_out), .write_strobe_pin_oe_n(wr_oe_n),
    .write_strobe_pin_own(wr_own), .byte_enable_pin_out(be_out), .byte_enable_pin_oe_n(be_oe_n),
    .byte_enable_pin_own(be_own), .chip_select_pin_in(cs_in), .chip_select_pin_out(),
    .chip_select_pin_oe_n(), .chip_select_pin_own(), .input_level_sel());
  ppch_periph per (.hclk(hclk), .data_pins_out(d_out), .write_strobe_pin_out(wr_out),
    .write_strobe_pin_oe_n(wr_oe_n), .byte_enable_pin_out(be_out), .byte_enable_pin_oe_n(be_oe_n),
    .data_pins_in(d_in), .address_pins_in(a_in), .read_strobe_pin_in(rd_in),
    .write_strobe_pin_in(wr_in), .chip_select_pin_in(cs_in));
  task automatic ahb(input logic [11:0] idx, input logic w, input logic [7:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] r;
    ahb(idx, 1'b1, d, r);
  endtask : wr
  task automatic chk(input logic [11:0] idx, input logic [7:0] e);
    logic [31:0] r;
    ahb(idx, 1'b0, 8'h00, r);
    `CHK(r, {24'h0, e})
  endtask : chk
  task automatic wait_idle();
    logic [31:0] r;
    do ahb(ppch_pkg::IDX_MODE_HI, 1'b0, 8'h00, r); while (r[7] !== 1'b0);
  endtask : wait_idle
  task automatic end_of_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // Whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(ppch_pkg::IDX_CTL_HI, 8'h00);
    chk(12'hF40, 8'h00);
    // Active-high polarities, so idle-low slave lines stay inactive
    wr(ppch_pkg::IDX_CTL_LO, 8'h0F);
    for (int m = 0; m < 4; m++) begin
      wr(ppch_pkg::IDX_MODE_HI, 8'h80 | 8'(m));
      chk(ppch_pkg::IDX_MODE_HI, 8'(m));
    end
    for (int x = 0; x < 4; x++) begin
      wr(ppch_pkg::IDX_CTL_HI, 8'h60 | 8'(x << 3));
      chk(ppch_pkg::IDX_CTL_HI, 8'(x << 3));
    end
    wr(ppch_pkg::IDX_MODE_HI, 8'h06);
    wr(ppch_pkg::IDX_CTL_HI, 8'h07);
    wr(ppch_pkg::IDX_BUF0 + 12'h1, 8'hA5);
    wr(ppch_pkg::IDX_BUF0, 8'h3C);
    repeat (20) @(posedge hclk);
    `CHK({rd_own, wr_own, be_own}, 3'b000)
    `CHK(per.seen.size(), 0)
    wr(ppch_pkg::IDX_CTL_HI, 8'h87);
    repeat (2) @(posedge hclk);
    `CHK({rd_own, wr_own, be_own}, 3'b111)
    wr(ppch_pkg::IDX_BUF0 + 12'h1, 8'hA5);
    wr(ppch_pkg::IDX_BUF0, 8'h3C);
    wait_idle();
    `CHK(per.seen.size(), 2)
    `CHK(per.seen[0], 9'h03C)
    `CHK(per.seen[1], 9'h1A5)
    wr(ppch_pkg::IDX_MODE_HI, 8'h02);
    wr(ppch_pkg::IDX_BUF0, 8'hC3);
    wait_idle();
    `CHK(per.seen.size(), 3)
    `CHK(per.seen[2], 9'h0C3)
    wr(ppch_pkg::IDX_CTL_HI, 8'h97);
    wr(ppch_pkg::IDX_BUF0, 8'h5A);
    wait_idle();
    `CHK(per.seen.size(), 4)
    `CHK(per.seen[3], 9'h05A)
    wr(ppch_pkg::IDX_MODE_HI, 8'h01);
    per.host_write();
    per.host_write();
    chk(ppch_pkg::IDX_STAT_HI, 8'h0C);
    chk(ppch_pkg::IDX_STAT_LO, 8'h0C);
    end_of_test();
  end
endmodule : ppch_port_tb
`default_nettype wire

// ### src/ppch_master_seq.sv
`timescale 1ns/1ps
`default_nettype none
module ppch_master_seq (
  input wire logic hclk,
  input wire logic hresetn,
  ppch_seq_if.seq sif
);
  typedef enum logic [2:0] {S_IDLE, S_ALO, S_AHI, S_STRB, S_HOLD} ppch_seq_state_t;
  ppch_seq_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic hi_reg, hi_next;
  logic wr_reg, two_reg;
  logic [1:0] mux_reg;
  logic [15:0] addr_reg, wdata_reg, rdata_reg, rdata_next;
  logic done_reg, done_next;
  wire logic muxed = (mux_reg == ppch_pkg::MUX_LOW) || (mux_reg == ppch_pkg::MUX_ALL);
  wire logic all_bits = mux_reg == ppch_pkg::MUX_ALL;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hi_next = hi_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    case (state_reg)
      S_IDLE: begin
        hi_next = 1'b0;
        if (sif.start) begin
          if ((sif.mux == ppch_pkg::MUX_LOW) || (sif.mux == ppch_pkg::MUX_ALL)) begin
            state_next = S_ALO;
          end else begin
            state_next = S_STRB;
            cnt_next = sif.wait_cnt;
          end
        end
      end
      S_ALO: begin
        // High address byte only when all muxed
        if (all_bits) begin
          state_next = S_AHI;
        end else begin
          state_next = S_STRB;
          cnt_next = sif.wait_cnt;
        end
      end
      S_AHI: begin
        state_next = S_STRB;
        cnt_next = sif.wait_cnt;
      end
      S_STRB: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else begin
          state_next = S_HOLD;
          if (!wr_reg && hi_reg) begin
            rdata_next = {sif.din, rdata_reg[7:0]};
          end else if (!wr_reg) begin
            rdata_next = {rdata_reg[15:8], sif.din};
          end
        end
      end
      S_HOLD: begin
        if (two_reg && !hi_reg) begin
          hi_next = 1'b1;
          state_next = muxed ? S_ALO : S_STRB;
          cnt_next = sif.wait_cnt;
        end else begin
          state_next = S_IDLE;
          done_next = 1'b1;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      hi_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
    end
  end

  // Request fields held for the whole transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      two_reg <= 1'b0;
      mux_reg <= 2'h0;
      addr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
    end else if (sif.start && (state_reg == S_IDLE)) begin
      wr_reg <= sif.wr;
      two_reg <= sif.two_bytes;
      mux_reg <= sif.mux;
      addr_reg <= sif.addr;
      wdata_reg <= sif.wdata;
    end
  end

  assign sif.busy = state_reg != S_IDLE;
  assign sif.done = done_reg;
  assign sif.cur_wr = wr_reg;
  assign sif.rdata = rdata_reg;
  assign sif.hi_byte = hi_reg;
  assign sif.latch_lo = state_reg == S_ALO;
  assign sif.latch_hi = state_reg == S_AHI;
  assign sif.rd_act = (state_reg == S_STRB) && !wr_reg;
  assign sif.wr_act = (state_reg == S_STRB) && wr_reg;
  assign sif.drive_data = (state_reg == S_ALO) || (state_reg == S_AHI) ||
    (wr_reg && ((state_reg == S_STRB) || (state_reg == S_HOLD)));
  assign sif.dout = (state_reg == S_ALO) ? addr_reg[7:0] :
    (state_reg == S_AHI) ? addr_reg[15:8] :
    hi_reg ? wdata_reg[15:8] : wdata_reg[7:0];
endmodule : ppch_master_seq
`default_nettype wire

// ### src/ppch_pkg.sv
package ppch_pkg;
  // Word indices; byte address is four times the index
  localparam int IDX_W = 12;
  localparam logic [11:0] IDX_CTL_HI = 12'hF5F;
  localparam logic [11:0] IDX_CTL_LO = 12'hF5E;
  localparam logic [11:0] IDX_MODE_HI = 12'hF5D;
  localparam logic [11:0] IDX_MODE_LO = 12'hF5C;
  localparam logic [11:0] IDX_BUF0 = 12'hF58;
  localparam logic [11:0] IDX_EN_HI = 12'hF57;
  localparam logic [11:0] IDX_EN_LO = 12'hF56;
  localparam logic [11:0] IDX_STAT_HI = 12'hF55;
  localparam logic [11:0] IDX_STAT_LO = 12'hF54;
  localparam logic [11:0] IDX_ADDR_HI = 12'hF53;
  localparam logic [11:0] IDX_ADDR_LO = 12'hF52;
  localparam logic [11:0] IDX_CFG = 12'hF50;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 13;
  // Field positions
  localparam int CTL_ON = 7;
  localparam int CTL_MUX_LSB = 3;
  localparam int CTL_BE = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;
  localparam int POL_CSF_LSB = 6;
  localparam int POL_AL = 5;
  localparam int POL_CS = 3;
  localparam int POL_BE = 2;
  localparam int POL_WR = 1;
  localparam int POL_RD = 0;
  localparam int MODE_BUSY = 7;
  localparam int MODE_W16 = 2;
  localparam int MODE_LSB = 0;
  localparam int WAITM_LSB = 2;
  localparam int EN_CS = 6;
  localparam int STAT_FULL = 7;
  localparam int STAT_OVF = 6;
  localparam int STAT_EMPTY = 7;
  // Write masks and reset values
  localparam logic [7:0] CTL_HI_MASK = 8'h9F;
  localparam logic [7:0] CTL_LO_MASK = 8'hEF;
  localparam logic [7:0] MODE_HI_MASK = 8'h7F;
  localparam logic [7:0] EN_HI_MASK = 8'h40;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] OUT_EMPTY_RST = 4'hF;
  localparam logic [7:0] LATCH_PINS = 8'h03;
  localparam logic [7:0] ALL_PINS = 8'hFF;
  localparam logic [1:0] CSF_ON = 2'h2;
  typedef enum logic [1:0] {MUX_SEP = 2'h0, MUX_LOW = 2'h1, MUX_ALL = 2'h2, MUX_RSVD = 2'h3} ppch_mux_t;
  typedef enum logic [1:0] {MODE_LEGACY = 2'h0, MODE_ENH = 2'h1, MODE_M2 = 2'h2, MODE_M1 = 2'h3} ppch_mode_t;
endpackage : ppch_pkg

// ### src/ppch_port.sv
`timescale 1ns/1ps
`default_nettype none
module ppch_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] data_pins_in,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe_n,
  input wire logic [1:0] address_pins_in,
  output logic [7:0] address_pins_out,
  output logic [7:0] address_pins_oe_n,
  input wire logic read_strobe_pin_in,
  output logic read_strobe_pin_out,
  output logic read_strobe_pin_oe_n,
  output logic read_strobe_pin_own,
  input wire logic write_strobe_pin_in,
  output logic write_strobe_pin_out,
  output logic write_strobe_pin_oe_n,
  output logic write_strobe_pin_own,
  output logic byte_enable_pin_out,
  output logic byte_enable_pin_oe_n,
  output logic byte_enable_pin_own,
  input wire logic chip_select_pin_in,
  output logic chip_select_pin_out,
  output logic chip_select_pin_oe_n,
  output logic chip_select_pin_own,
  output logic input_level_sel
);
  // Pin level from activity and polarity bit (1 = active high)
  function automatic logic lvl(input logic act, input logic pol);
    lvl = act ~^ pol;
  endfunction : lvl

  function automatic logic [3:0] dec4(input logic [1:0] i);
    dec4 = 4'h1 << i;
  endfunction : dec4

  ppch_seq_if sif();
  ppch_master_seq u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .sif(sif)
  );

  // Bus slave: reads take one wait state so a preceding write is visible
  logic wr_pend_reg, rd_pend_reg;
  logic [11:0] idx_reg;
  logic [31:0] hrdata_reg;
  wire logic take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 12'h000;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      idx_reg <= take ? haddr[ppch_pkg::IDX_MSB:ppch_pkg::IDX_LSB] : idx_reg;
    end
  end
  wire logic [7:0] wbyte = hwdata[7:0];
  wire logic sel_ctl_hi = idx_reg == ppch_pkg::IDX_CTL_HI;
  wire logic sel_ctl_lo = idx_reg == ppch_pkg::IDX_CTL_LO;
  wire logic sel_mode_hi = idx_reg == ppch_pkg::IDX_MODE_HI;
  wire logic sel_mode_lo = idx_reg == ppch_pkg::IDX_MODE_LO;
  wire logic sel_en_hi = idx_reg == ppch_pkg::IDX_EN_HI;
  wire logic sel_en_lo = idx_reg == ppch_pkg::IDX_EN_LO;
  wire logic sel_stat_hi = idx_reg == ppch_pkg::IDX_STAT_HI;
  wire logic sel_addr_hi = idx_reg == ppch_pkg::IDX_ADDR_HI;
  wire logic sel_addr_lo = idx_reg == ppch_pkg::IDX_ADDR_LO;
  wire logic sel_cfg = idx_reg == ppch_pkg::IDX_CFG;
  wire logic sel_buf = idx_reg[11:2] == ppch_pkg::IDX_BUF0[11:2];
  wire logic [3:0] sw_wr_buf = (wr_pend_reg && sel_buf) ? dec4(idx_reg[1:0]) : 4'h0;
  wire logic [3:0] sw_rd_buf = (rd_pend_reg && sel_buf) ? dec4(idx_reg[1:0]) : 4'h0;
  wire logic wr_en = wr_pend_reg;

  logic [7:0] ctl_hi_reg, ctl_lo_reg, mode_hi_reg, mode_lo_reg, en_hi_reg, en_lo_reg;
  logic [7:0] addr_hi_reg, addr_lo_reg, cfg_reg;
  // Control bits clear at reset, unused bits masked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_hi_reg <= ppch_pkg::REG_RST;
      ctl_lo_reg <= ppch_pkg::REG_RST;
      mode_hi_reg <= ppch_pkg::REG_RST;
      mode_lo_reg <= ppch_pkg::REG_RST;
      en_hi_reg <= ppch_pkg::REG_RST;
      en_lo_reg <= ppch_pkg::REG_RST;
      addr_hi_reg <= ppch_pkg::REG_RST;
      addr_lo_reg <= ppch_pkg::REG_RST;
      cfg_reg <= ppch_pkg::REG_RST;
    end else begin
      if (wr_en && sel_ctl_hi) ctl_hi_reg <= wbyte & ppch_pkg::CTL_HI_MASK;
      if (wr_en && sel_ctl_lo) ctl_lo_reg <= wbyte & ppch_pkg::CTL_LO_MASK;
      if (wr_en && sel_mode_hi) mode_hi_reg <= wbyte & ppch_pkg::MODE_HI_MASK;
      if (wr_en && sel_mode_lo) mode_lo_reg <= wbyte;
      if (wr_en && sel_en_hi) en_hi_reg <= wbyte & ppch_pkg::EN_HI_MASK;
      if (wr_en && sel_en_lo) en_lo_reg <= wbyte;
      if (wr_en && sel_addr_hi) addr_hi_reg <= wbyte;
      if (wr_en && sel_addr_lo) addr_lo_reg <= wbyte;
      if (wr_en && sel_cfg) cfg_reg <= wbyte;
    end
  end

  // Configuration decode
  // Master, slave and pin enables gated by module on; mode, mux, w16 and cs_func are not
  wire logic on = ctl_hi_reg[ppch_pkg::CTL_ON];
  wire logic [1:0] mode = mode_hi_reg[ppch_pkg::MODE_LSB +: 2];
  // Master for modes 1x, slave for 0x
  wire logic master = on && mode[1];
  wire logic slave = on && !mode[1];
  wire logic mode1 = mode == ppch_pkg::MODE_M1;
  wire logic enhanced = mode == ppch_pkg::MODE_ENH;
  wire logic [1:0] mux = ctl_hi_reg[ppch_pkg::CTL_MUX_LSB +: 2];
  // Reserved mux value behaves as separate pins
  wire logic mux_sep = (mux == ppch_pkg::MUX_SEP) || (mux == ppch_pkg::MUX_RSVD);
  wire logic w16 = mode_hi_reg[ppch_pkg::MODE_W16];
  wire logic rd_pin_en = on && ctl_hi_reg[ppch_pkg::CTL_RD];
  wire logic wr_pin_en = on && ctl_hi_reg[ppch_pkg::CTL_WR];
  wire logic be_pin_en = on && ctl_hi_reg[ppch_pkg::CTL_BE];
  wire logic cs_pin_en = on && en_hi_reg[ppch_pkg::EN_CS];
  wire logic cs_func = ctl_lo_reg[ppch_pkg::POL_CSF_LSB +: 2] == ppch_pkg::CSF_ON;

  // Two-flop synchronisers for every pin input
  logic [12:0] sync1_reg, sync2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 13'h0000;
      sync2_reg <= 13'h0000;
    end else begin
      sync1_reg <= {data_pins_in, address_pins_in, read_strobe_pin_in, write_strobe_pin_in, chip_select_pin_in};
      sync2_reg <= sync1_reg;
    end
  end
  wire logic [7:0] din_s = sync2_reg[12:5];
  wire logic [1:0] ain_s = sync2_reg[4:3];
  wire logic cs_s = lvl(sync2_reg[0], ctl_lo_reg[ppch_pkg::POL_CS]);
  wire logic rd_s = slave && cs_s && rd_pin_en && lvl(sync2_reg[2], ctl_lo_reg[ppch_pkg::POL_RD]);
  wire logic wr_s = slave && cs_s && wr_pin_en && lvl(sync2_reg[1], ctl_lo_reg[ppch_pkg::POL_WR]);

  // Slave strobe edges
  logic prev_rd_reg, prev_wr_reg, prev_cs_reg;
  logic [1:0] sidx_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_rd_reg <= 1'b0;
      prev_wr_reg <= 1'b0;
      prev_cs_reg <= 1'b0;
    end else begin
      prev_rd_reg <= rd_s;
      prev_wr_reg <= wr_s;
      prev_cs_reg <= slave && cs_s;
    end
  end
  wire logic rd_end = prev_rd_reg && !rd_s;
  wire logic wr_end = prev_wr_reg && !wr_s;
  wire logic cs_start = slave && cs_s && !prev_cs_reg;
  wire logic [3:0] host_wr = wr_end ? dec4(sidx_reg) : 4'h0;
  wire logic [3:0] host_rd = rd_end ? dec4(sidx_reg) : 4'h0;

  // Enhanced slave mode: index reloads from address inputs, then auto-increments; held at 0 otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sidx_reg <= 2'h0;
    end else if (!enhanced || !slave) begin
      sidx_reg <= 2'h0;
    end else if (cs_start) begin
      sidx_reg <= ain_s;
    end else if (rd_end || wr_end) begin
      sidx_reg <= sidx_reg + 2'h1;
    end
  end

  // Buffer flags: hardware set wins over software clear
  logic [3:0] in_full_reg, out_empty_reg;
  logic ovf_reg;
  wire logic ovf_set = wr_end && in_full_reg[sidx_reg];
  wire logic ovf_clr = wr_en && sel_stat_hi && !wbyte[ppch_pkg::STAT_OVF];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_full_reg <= 4'h0;
      out_empty_reg <= ppch_pkg::OUT_EMPTY_RST;
      ovf_reg <= 1'b0;
    end else begin
      in_full_reg <= (in_full_reg & ~sw_rd_buf) | host_wr;
      out_empty_reg <= (out_empty_reg & ~sw_wr_buf) | host_rd;
      ovf_reg <= ovf_set || (ovf_reg && !ovf_clr);
    end
  end

  // Master transfer starts on data register access
  wire logic start_wr = master && wr_en && sw_wr_buf[0];
  wire logic start_rd = master && sw_rd_buf[0];
  logic [7:0] buf_reg [4];
  assign sif.start = (start_wr || start_rd) && !sif.busy;
  assign sif.wr = start_wr;
  assign sif.two_bytes = w16;
  assign sif.mux = mux;
  assign sif.wait_cnt = mode_lo_reg[ppch_pkg::WAITM_LSB +: 4];
  assign sif.addr = {addr_hi_reg, addr_lo_reg};
  assign sif.wdata = {buf_reg[1], wbyte};
  assign sif.din = din_s;
  wire logic master_rd_done = sif.done && !sif.cur_wr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < 4; k++) buf_reg[k] <= ppch_pkg::REG_RST;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (host_wr[k]) begin
          buf_reg[k] <= din_s;
        end else if (master_rd_done && (k == 0)) begin
          buf_reg[k] <= sif.rdata[7:0];
        end else if (master_rd_done && (k == 1) && w16) begin
          buf_reg[k] <= sif.rdata[15:8];
        end else if (sw_wr_buf[k]) begin
          buf_reg[k] <= wbyte;
        end
      end
    end
  end

  // Read mux; reads return state as it stands after any prior write
  wire logic [7:0] stat_hi = {&in_full_reg, ovf_reg, 2'h0, in_full_reg};
  wire logic [7:0] stat_lo = {&out_empty_reg, 3'h0, out_empty_reg};
  wire logic [7:0] mode_rd = {sif.busy, mode_hi_reg[6:0]};
  wire logic [7:0] rd_mux = sel_ctl_hi ? ctl_hi_reg :
    sel_ctl_lo ? ctl_lo_reg :
    sel_mode_hi ? mode_rd :
    sel_mode_lo ? mode_lo_reg :
    sel_en_hi ? en_hi_reg :
    sel_en_lo ? en_lo_reg :
    sel_stat_hi ? stat_hi :
    (idx_reg == ppch_pkg::IDX_STAT_LO) ? stat_lo :
    sel_addr_hi ? addr_hi_reg :
    sel_addr_lo ? addr_lo_reg :
    sel_cfg ? cfg_reg :
    sel_buf ? buf_reg[idx_reg[1:0]] : 8'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= {24'h000000, rd_mux};
    end
  end
  assign hrdata = hrdata_reg;
  assign hreadyout = !rd_pend_reg;
  assign hresp = 1'b0;

  // Pin next values
  // Mode 1: rw level plus enable strobe; mode 2: separate strobes
  wire logic rd_act_m = mode1 ? (sif.busy && !sif.cur_wr) : sif.rd_act;
  wire logic wr_act_m = mode1 ? (sif.rd_act || sif.wr_act) : sif.wr_act;
  // Separate pins carry low address; muxed use pins 0/1 as latches
  wire logic al_pol = ctl_lo_reg[ppch_pkg::POL_AL];
  wire logic [7:0] addr_val = mux_sep ? addr_lo_reg :
    {6'h00, lvl(sif.latch_hi, al_pol), lvl(sif.latch_lo, al_pol)};
  wire logic [7:0] addr_drv = en_lo_reg & {8{master}} & (mux_sep ? ppch_pkg::ALL_PINS : ppch_pkg::LATCH_PINS);
  wire logic data_drv = master ? sif.drive_data : rd_s;
  wire logic [7:0] data_val = master ? sif.dout : buf_reg[sidx_reg];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_pins_out <= 8'h00;
      data_pins_oe_n <= 1'b1;
      address_pins_out <= 8'h00;
      address_pins_oe_n <= 8'hFF;
    end else begin
      data_pins_out <= data_val;
      data_pins_oe_n <= !(on && data_drv);
      address_pins_out <= addr_val;
      address_pins_oe_n <= ~addr_drv;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_strobe_pin_out <= 1'b0;
      read_strobe_pin_oe_n <= 1'b1;
      write_strobe_pin_out <= 1'b0;
      write_strobe_pin_oe_n <= 1'b1;
      byte_enable_pin_out <= 1'b0;
      byte_enable_pin_oe_n <= 1'b1;
      chip_select_pin_out <= 1'b0;
      chip_select_pin_oe_n <= 1'b1;
    end else begin
      read_strobe_pin_out <= lvl(rd_act_m, ctl_lo_reg[ppch_pkg::POL_RD]);
      read_strobe_pin_oe_n <= !(master && rd_pin_en);
      write_strobe_pin_out <= lvl(wr_act_m, ctl_lo_reg[ppch_pkg::POL_WR]);
      write_strobe_pin_oe_n <= !(master && wr_pin_en);
      // Byte enable marks the high byte of a 16-bit transfer
      byte_enable_pin_out <= lvl(sif.busy && sif.hi_byte, ctl_lo_reg[ppch_pkg::POL_BE]);
      byte_enable_pin_oe_n <= !(master && be_pin_en);
      chip_select_pin_out <= lvl(sif.busy, ctl_lo_reg[ppch_pkg::POL_CS]);
      chip_select_pin_oe_n <= !(master && cs_pin_en && cs_func);
    end
  end

  // Ownership back to general port logic when disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_strobe_pin_own <= 1'b0;
      write_strobe_pin_own <= 1'b0;
      byte_enable_pin_own <= 1'b0;
      chip_select_pin_own <= 1'b0;
      input_level_sel <= 1'b0;
    end else begin
      read_strobe_pin_own <= rd_pin_en;
      write_strobe_pin_own <= wr_pin_en;
      byte_enable_pin_own <= be_pin_en;
      chip_select_pin_own <= cs_pin_en;
      input_level_sel <= cfg_reg[0];
    end
  end
endmodule : ppch_port
`default_nettype wire

// ### src/ppch_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppch_seq_if;
  logic start;
  logic wr;
  logic two_bytes;
  logic [1:0] mux;
  logic [3:0] wait_cnt;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [7:0] din;
  logic busy;
  logic done;
  logic cur_wr;
  logic [15:0] rdata;
  logic drive_data;
  logic [7:0] dout;
  logic latch_lo;
  logic latch_hi;
  logic rd_act;
  logic wr_act;
  logic hi_byte;
  modport ctl (output start, wr, two_bytes, mux, wait_cnt, addr, wdata, din,
    input busy, done, cur_wr, rdata, drive_data, dout, latch_lo, latch_hi, rd_act, wr_act, hi_byte);
  modport seq (input start, wr, two_bytes, mux, wait_cnt, addr, wdata, din,
    output busy, done, cur_wr, rdata, drive_data, dout, latch_lo, latch_hi, rd_act, wr_act, hi_byte);
endinterface : ppch_seq_if
`default_nettype wire
